// *** verilog/clsr_regs.v ***
`timescale 1ns/100ps
`default_nettype none
`include "clsr_consts.vh"
module clsr_regs #(
  parameter HIGH_VOLT_VARIANT = 1'b0  // 1: 4-bit current code, ceiling
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  // register port from the serial front end
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  output reg  [7:0]  reg_rdata,
  // register contents of 02 and 04 held elsewhere
  input  wire [7:0]  vreg_reg,
  input  wire [7:0]  ichg_reg,
  // analog status and pins
  input  wire        input_power_limiting,
  input  wire        charge_disable_pin,
  input  wire        sense_below_short,
  input  wire        limit_reset_pin_n,
  // effective decoded outputs
  output reg  [15:0] sense_target_tenth_mv,
  output reg  [15:0] regulation_mv,
  output reg  [15:0] special_voltage_mv,
  output reg  [15:0] max_current_tenth_mv,
  output reg  [15:0] max_voltage_mv,
  output reg         low_current_select,
  output reg         safety_locked
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  reg  [7:0] safety_q;      // safety limit register
  reg        locked_q;      // lock after foreign write
  reg        lowcur_q;      // low-current select
  reg  [2:0] spv_q;         // special charger voltage code
  reg  [1:0] spare_q;       // read/write bits 7..6
  wire       lim_s;         // synced limiting flag
  wire       cd_s;          // synced charge-disable pin
  wire       short_s;       // synced short detect
  wire       limit_reset_pin_n_s;     // synced limit reset pin
  wire       safety_rst;    // safety domain reset
  wire       wr_safety;     // write to safety register
  wire       wr_special;    // write to special register
  wire       wr_other;      // write to any other register
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  clsr_sync2 u_sync_lim (.clk_sys(clk_sys), .nrst(nrst),
    .din(input_power_limiting), .dout(lim_s));
  clsr_sync2 u_sync_cd (.clk_sys(clk_sys), .nrst(nrst),
    .din(charge_disable_pin), .dout(cd_s));
  // safety sources must not depend on nrst, so own flops
  reg sh1_q, sh2_q, sr1_q, sr2_q;
  always @(posedge clk_sys) begin
    sh1_q <= sense_below_short;
    sh2_q <= sh1_q;
    sr1_q <= limit_reset_pin_n;
    sr2_q <= sr1_q;
  end
  assign short_s    = sh2_q;
  assign limit_reset_pin_n_s  = sr2_q;
  assign safety_rst = short_s | ~limit_reset_pin_n_s;
  // ----------------------------------------
  // write decode
  // ----------------------------------------
  assign wr_safety  = reg_wr & (reg_addr == `CLSR_ADDR_SAFETY);
  assign wr_special = reg_wr & (reg_addr == `CLSR_ADDR_SPECIAL);
  assign wr_other   = reg_wr & (reg_addr != `CLSR_ADDR_SAFETY);
  // ----------------------------------------
  // safety register and lock, reset only by short or pin
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (safety_rst) begin
      safety_q <= `CLSR_SAFETY_RST;
      locked_q <= 1'b0;
    end else begin
      if (wr_other)
        locked_q <= 1'b1;
      if (wr_safety && !locked_q)
        safety_q <= reg_wdata;
    end
  end
  // ----------------------------------------
  // special voltage register, normal reset
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      lowcur_q <= `CLSR_SP_RST_LOWCUR;
      spv_q    <= `CLSR_SP_RST_VOLT;
      spare_q  <= 2'h0;
    end else if (wr_special) begin
      spare_q  <= reg_wdata[7:6];
      lowcur_q <= reg_wdata[`CLSR_SP_LOWCUR_BIT];
      spv_q    <= reg_wdata[2:0];  // bits 4,3 ignored
    end
  end
  // ----------------------------------------
  // readback
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst)
      reg_rdata <= 8'h00;
    else if (reg_addr == `CLSR_ADDR_SPECIAL)
      reg_rdata <= {spare_q, lowcur_q, lim_s, cd_s, spv_q};
    else if (reg_addr == `CLSR_ADDR_SAFETY)
      reg_rdata <= safety_q;
    else
      reg_rdata <= 8'h00;
  end
  // ----------------------------------------
  // clamp and decode
  // ----------------------------------------
  reg [3:0] ich_code;   // clamped current code
  reg [5:0] vr_code;    // clamped voltage code
  reg [5:0] vr_max;     // voltage limit as 02 code
  reg [3:0] ich_raw;    // programmed current code
  always @* begin
    // 3-bit code in low variant, MSB weight 27.2 mV
    if (HIGH_VOLT_VARIANT)
      ich_raw = ichg_reg[`CLSR_ICHG_MSB:`CLSR_ICHG_LSB];
    else
      ich_raw = {1'b0, ichg_reg[`CLSR_ICHG_MSB:`CLSR_ICHG_LSB+1]};
    ich_code = (ich_raw > safety_q[7:4]) ? safety_q[7:4] : ich_raw;
    if (HIGH_VOLT_VARIANT && ich_code > `CLSR_HV_ICHG_CEIL)
      ich_code = `CLSR_HV_ICHG_CEIL;
    // limit 4.2V + n*20mV equals 02 code 35 + n
    vr_max  = 6'd35 + {2'b00, safety_q[3:0]};
    vr_code = vreg_reg[`CLSR_VREG_MSB:`CLSR_VREG_LSB];
    if (vr_code > vr_max)
      vr_code = vr_max;
  end
  always @(posedge clk_sys) begin
    if (!nrst) begin
      sense_target_tenth_mv <= 16'h0000;
      regulation_mv         <= 16'h0000;
      special_voltage_mv    <= 16'h0000;
      max_current_tenth_mv  <= 16'h0000;
      max_voltage_mv        <= 16'h0000;
      low_current_select    <= 1'b0;
      safety_locked         <= 1'b0;
    end else begin
      if (lowcur_q)
        sense_target_tenth_mv <= `CLSR_LOWCUR_SENSE;
      else
        sense_target_tenth_mv <= `CLSR_ICHG_BASE +
          `CLSR_ICHG_STEP * {12'h000, ich_code};
      regulation_mv <= `CLSR_VREG_BASE +
        `CLSR_VREG_STEP * {10'h000, vr_code};
      special_voltage_mv <= `CLSR_SPV_BASE +
        `CLSR_SPV_STEP * {13'h0000, spv_q};
      max_current_tenth_mv <= `CLSR_ICHG_BASE +
        `CLSR_ICHG_STEP * {12'h000, safety_q[7:4]};
      max_voltage_mv <= `CLSR_MAXV_BASE +
        `CLSR_MAXV_STEP * {12'h000, safety_q[3:0]};
      low_current_select <= lowcur_q;
      safety_locked      <= locked_q;
    end
  end
endmodule // clsr_regs
`default_nettype wire

// *** include/clsr_consts.vh ***
`ifndef CLSR_CONSTS_VH
`define CLSR_CONSTS_VH
// register addresses
`define CLSR_ADDR_VREG       8'h02
`define CLSR_ADDR_ICHG       8'h04
`define CLSR_ADDR_SPECIAL    8'h05
`define CLSR_ADDR_SAFETY     8'h06
// special register fields and reset bits
`define CLSR_SP_LOWCUR_BIT   5
`define CLSR_SP_LIMIT_BIT    4
`define CLSR_SP_PIN_BIT      3
`define CLSR_SP_RST_LOWCUR   1'b1
`define CLSR_SP_RST_VOLT     3'h4
// safety register reset value
`define CLSR_SAFETY_RST      8'h40
// fast-charge current field of register 04
`define CLSR_ICHG_MSB        6
`define CLSR_ICHG_LSB        3
// regulation voltage field of register 02
`define CLSR_VREG_MSB        7
`define CLSR_VREG_LSB        2
// decode bases and steps, in 0.1 mV units
`define CLSR_LOWCUR_SENSE    16'd0221
`define CLSR_ICHG_BASE       16'd0374
`define CLSR_ICHG_STEP       16'd0068
// high-voltage ceiling: code 10, 37.4 + 10*6.8 = 105.4 mV sense
`define CLSR_HV_ICHG_CEIL    4'hA
// voltages in mV
`define CLSR_VREG_BASE       16'd3500
`define CLSR_VREG_STEP       16'd0020
`define CLSR_SPV_BASE        16'd4200
`define CLSR_SPV_STEP        16'd0080
`define CLSR_MAXV_BASE       16'd4200
`define CLSR_MAXV_STEP       16'd0020
`endif

// *** verilog/clsr_sync2.v ***
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for a pin level
module clsr_sync2 (
  // clock and reset
  input  wire clk_sys,
  input  wire nrst,
  // asynchronous level in, synchronised out
  input  wire din,
  output wire dout
);
  reg s1_q;  // first stage, read only by second
  reg s2_q;  // second stage
  // ----------------------------------------
  // shift the level through two flops
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
    end
  end
  assign dout = s2_q;
endmodule // clsr_sync2
`default_nettype wire

// *** verification/clsr_host_regs.sv ***
`timescale 1ns/100ps
`default_nettype none
// host-side copies of registers 02 and 04
module clsr_host_regs (
  input  wire       clk_sys, nrst, reg_wr,
  input  wire [7:0] reg_addr, reg_wdata,
  output reg  [7:0] vreg_reg, ichg_reg
);
  always @(posedge clk_sys) begin
    if (!nrst) begin
      vreg_reg <= 8'h0A;
      ichg_reg <= 8'h01;
    end else if (reg_wr && reg_addr == 8'h02) begin
      vreg_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == 8'h04) begin
      ichg_reg <= reg_wdata;
    end
  end
endmodule // clsr_host_regs
`default_nettype wire

// *** verification/clsr_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module clsr_monitor (
  // clock, reset and strobes
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        reg_wr,
  // pins
  input wire logic        sense_below_short,
  input wire logic        limit_reset_pin_n,
  input wire logic        charge_disable_pin,
  input wire logic        input_power_limiting,
  // status
  input wire logic        low_current_select,
  input wire logic        safety_locked,
  // register port
  input wire logic [7:0]  reg_addr,
  input wire logic [7:0]  reg_rdata,
  // decoded values
  input wire logic [15:0] sense_target_tenth_mv,
  input wire logic [15:0] regulation_mv,
  input wire logic [15:0] max_current_tenth_mv,
  input wire logic [15:0] max_voltage_mv
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // no safety reset source active
  wire quiet = !sense_below_short && limit_reset_pin_n;
  chk_other_locks: assert property (
    quiet && reg_wr && reg_addr != 8'h06 |-> ##[1:2] safety_locked)
    else $error("lock not set");
  chk_short_default: assert property (
    sense_below_short [*4] |-> ##2
    (max_current_tenth_mv == 16'h0286 && max_voltage_mv == 16'h1068))
    else $error("short reset defaults wrong");
  chk_pin_unlocks: assert property (
    !limit_reset_pin_n [*4] |-> ##2 !safety_locked)
    else $error("pin reset left lock");
  chk_pin_status: assert property (
    charge_disable_pin [*4] ##0 reg_addr == 8'h05 |=> reg_rdata[3])
    else $error("pin status bit wrong");
  chk_limit_flag: assert property (
    input_power_limiting [*4] ##0 reg_addr == 8'h05 |=> reg_rdata[4])
    else $error("limiting flag wrong");
  chk_low_sense: assert property (
    low_current_select && $past(low_current_select)
    |-> sense_target_tenth_mv == 16'h00DD)
    else $error("low current target wrong");
  chk_volt_clamp: assert property (
    safety_locked && $past(safety_locked) |-> regulation_mv <= max_voltage_mv)
    else $error("voltage above limit");
  chk_cur_clamp: assert property (
    safety_locked && !low_current_select && $stable(low_current_select)
    |-> sense_target_tenth_mv <= max_current_tenth_mv)
    else $error("current above limit");
endmodule // clsr_monitor
`default_nettype wire

// *** verification/clsr_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module clsr_regs_tb;
  reg clk_sys = 0, nrst = 0, reg_wr = 0, input_power_limiting = 0;
  reg charge_disable_pin = 1, sense_below_short = 1, limit_reset_pin_n = 1;
  reg  [7:0]  reg_addr = 0, reg_wdata = 0;
  wire [7:0]  reg_rdata, vreg_reg, ichg_reg;
  wire [15:0] st, rv, sv, mc, mv;
  wire [15:0] st_hv;  // sense target of the high-voltage variant
  wire        lcs, lck;
  integer     num_errors = 0, checks_done = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  clsr_host_regs u_host (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .vreg_reg(vreg_reg),
    .ichg_reg(ichg_reg));
  clsr_regs u_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .vreg_reg(vreg_reg), .ichg_reg(ichg_reg),
    .input_power_limiting(input_power_limiting),
    .charge_disable_pin(charge_disable_pin),
    .sense_below_short(sense_below_short),
    .limit_reset_pin_n(limit_reset_pin_n), .sense_target_tenth_mv(st),
    .regulation_mv(rv), .special_voltage_mv(sv), .max_current_tenth_mv(mc),
    .max_voltage_mv(mv), .low_current_select(lcs), .safety_locked(lck));
  clsr_regs #(.HIGH_VOLT_VARIANT(1'b1)) u_dut_hv (.clk_sys(clk_sys),
    .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(), .vreg_reg(vreg_reg),
    .ichg_reg(ichg_reg), .input_power_limiting(input_power_limiting),
    .charge_disable_pin(charge_disable_pin),
    .sense_below_short(sense_below_short),
    .limit_reset_pin_n(limit_reset_pin_n),
    .sense_target_tenth_mv(st_hv), .regulation_mv(),
    .special_voltage_mv(), .max_current_tenth_mv(), .max_voltage_mv(),
    .low_current_select(), .safety_locked());
  task results;
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_sys) #1 reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(posedge clk_sys) #1 reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_sys) #1 reg_addr = a;
      repeat (2) @(posedge clk_sys);
      #1 chk({8'h00, reg_rdata}, {8'h00, e});
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    #1 sense_below_short = 0;
    repeat (4) @(posedge clk_sys);
    #1 nrst = 1;
    rd(8'h05, 8'h2C);
    chk(sv, 16'h11A8);
    chk(st, 16'h00DD);
    rd(8'h06, 8'h40);
    chk(mc, 16'h0286);
    chk(mv, 16'h1068);
    wr(8'h06, 8'h2F);
    rd(8'h06, 8'h2F);
    chk(mv, 16'h1194);
    chk(mc, 16'h01FE);
    wr(8'h06, 8'h13);
    input_power_limiting = 1;
    charge_disable_pin = 0;
    wr(8'h05, 8'h0B);
    rd(8'h05, 8'h13);
    chk(sv, 16'h1158);
    chk({15'd0, lck}, 16'h0001);
    wr(8'h06, 8'hFF);
    wr(8'h02, 8'hFC);
    wr(8'h04, 8'h70);
    rd(8'h06, 8'h13);
    chk(rv, 16'h10A4);
    chk(st, 16'h01BA);
    @(posedge clk_sys) #1 nrst = 0;
    @(posedge clk_sys) #1 nrst = 1;
    rd(8'h06, 8'h13);
    limit_reset_pin_n = 0;
    repeat (4) @(posedge clk_sys);
    #1 limit_reset_pin_n = 1;
    rd(8'h06, 8'h40);
    wr(8'h04, 8'h01);
    wr(8'h06, 8'h2F);
    rd(8'h06, 8'h40);
    sense_below_short = 1;
    repeat (4) @(posedge clk_sys);
    #1 sense_below_short = 0;
    rd(8'h06, 8'h40);
    chk({15'd0, lck}, 16'h0000);
    wr(8'h06, 8'hF0);
    wr(8'h05, 8'h00);
    wr(8'h04, 8'h7F);
    rd(8'h06, 8'hF0);
    chk(mc, 16'h0572);
    chk(st, 16'h0352);
    chk(st_hv, 16'h041E);
    results;
  end
endmodule // clsr_regs_tb
bind clsr_regs clsr_monitor u_mon (.clk_sys(clk_sys), .nrst(nrst),
  .reg_wr(reg_wr), .sense_below_short(sense_below_short),
  .limit_reset_pin_n(limit_reset_pin_n),
  .charge_disable_pin(charge_disable_pin),
  .input_power_limiting(input_power_limiting),
  .low_current_select(low_current_select), .safety_locked(safety_locked),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata),
  .sense_target_tenth_mv(sense_target_tenth_mv),
  .regulation_mv(regulation_mv),
  .max_current_tenth_mv(max_current_tenth_mv),
  .max_voltage_mv(max_voltage_mv));
`default_nettype wire
